// ### verilog/psp_pkg.sv
// Constants and types shared by the power stage protection monitor
package psp_pkg;

    // --------------------
    // Clock, widths
    // --------------------
    localparam int MCLK_NS = 50;
    localparam int CNT_W = 24;
    localparam int VAL_W = 12;
    localparam int WORD_W = 32;
    localparam int RESTORE_W = 8;

    // --------------------
    // Times and derived cycle counts
    // --------------------
    localparam int OCP_BLANK_NS = 240;
    localparam int OCP_BLANK_CYC = (OCP_BLANK_NS + MCLK_NS - 1) / MCLK_NS;
    localparam int HALF_SINE_FIXED_NS = 9823000;
    localparam int HALF_SINE_FIXED_CYC = HALF_SINE_FIXED_NS / MCLK_NS;
    localparam int FAST_RESTART_MS = 400;
    localparam int FAST_RESTART_CYC = FAST_RESTART_MS * 1000000 / MCLK_NS;

    // --------------------
    // Level-two thresholds in mV, level-one setting in 10 mV steps
    // --------------------
    localparam logic [11:0] OCP2_LOW_MV = 12'h320;
    localparam logic [11:0] OCP2_MID_MV = 12'h4B0;
    localparam logic [11:0] OCP2_HIGH_MV = 12'h640;
    localparam logic [6:0] OCP1_MID_MIN = 7'h37;
    localparam logic [6:0] OCP1_HIGH_MIN = 7'h49;

    // --------------------
    // Register map: configuration words first, one word each
    // --------------------
    localparam int CFG_N = 14;
    localparam int CFG_CTRL = 0;
    localparam int CFG_OCP1 = 1;
    localparam int CFG_OCP_BLANK = 2;
    localparam int CFG_DIM_MIN = 3;
    localparam int CFG_UV_BLANK = 4;
    localparam int CFG_START_LVL = 5;
    localparam int CFG_START_TMO = 6;
    localparam int CFG_OV_LVL = 7;
    localparam int CFG_OV_RED = 8;
    localparam int CFG_BURST_BLANK = 9;
    localparam int CFG_IPK_LVL = 10;
    localparam int CFG_IPK_BLANK = 11;
    localparam int CFG_RESTORE_N = 12;
    localparam int CFG_RESTART = 13;
    localparam logic [7:0] ADDR_STATUS = 8'h38;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h3C;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h40;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h44;

    // Control word bits
    localparam int CTRL_PEAK_EN = 0;
    localparam int CTRL_ADAPT_EN = 1;
    localparam int CTRL_OV_LATCH = 2;
    localparam int CTRL_FAST = 3;

    // Fault and event bit positions
    localparam int F_OCP = 0;
    localparam int F_UV = 1;
    localparam int F_OV = 2;
    localparam int F_DEMAG = 3;
    localparam int F_IPK = 4;
    localparam int F_START = 5;
    localparam int NF = 6;
    localparam int EV_RESTORE = 6;
    localparam int NEV = 7;

    localparam logic [31:0] CFG_RST [CFG_N] = '{
        32'h0000_0000,
        32'h0000_0032,
        32'(OCP_BLANK_CYC),
        32'h0000_0200,
        32'h0000_4E20,
        32'h0000_0180,
        32'h0020_0000,
        32'h0000_0C00,
        32'h0000_0A00,
        32'h0000_4E20,
        32'h0000_0800,
        32'h0000_4E20,
        32'h0000_0004,
        32'h0040_0000
    };

    // --------------------
    // Types
    // --------------------
    typedef enum logic [1:0] {
        MODE_FIRST_VALLEY,
        MODE_DISCONTINUOUS,
        MODE_BURST
    } psp_mode_e;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_LATCH
    } psp_state_e;

    typedef struct packed {
        logic [VAL_W-1:0] cs_mv;
        logic [VAL_W-1:0] vout;
        logic [VAL_W-1:0] iout;
        logic demag_ok;
    } psp_sense_s;

endpackage

// ### verilog/psp_monitor.sv
// Protection monitor with blanking, reactions and adaptive overvoltage
//
// Operation
// - Current-sense above level two longer than blank time trips overcurrent.
// - Level two is 0.8, 1.2 or 1.6 V by level-one setting range.
// - Switch overcurrent always reacts with auto-restart.
// - Regulating output below undervoltage level past blanking: auto-restart.
// - Undervoltage level is half the fully dimmed minimum output voltage.
// - Startup output staying below startup level until timeout: auto-restart.
// - Overvoltage blank is quarter half-sine, or configurable in burst mode.
// - Half-sine period is fixed 9.823 ms or measured line period.
// - Overvoltage reacts with auto-restart or latch per setting.
// - Adaptive mode lowers overvoltage level and current limit on first trip.
// - Restore after reduced level held for configured half-sine count.
// - Output voltage unsensed over half a half-sine trips demag shortage.
// - Enabled peak output current above limit past blanking trips fault.
// - Peak current fault restarts after 0.4 s if fast, else configured time.
// - Any trip removes gate drive within 1/512 half-sine.
// - Latch holds until supply falls below the off threshold.
// - Fast auto-restart waits 0.4 s in the low-power state.
//
// Decided for this implementation: register access over APB and the placing of the registers.
module psp_monitor #(
    parameter int HALF_SINE_CYC = psp_pkg::HALF_SINE_FIXED_CYC,
    parameter int FAST_RESTART_CYC = psp_pkg::FAST_RESTART_CYC
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // APB slave
    input wire logic [7:0] PADDR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Sampled and estimated quantities
    input wire logic [psp_pkg::VAL_W-1:0] CS_MV,
    input wire logic [psp_pkg::VAL_W-1:0] VOUT_EST,
    input wire logic [psp_pkg::VAL_W-1:0] IOUT_EST,
    input wire logic ZERO_CROSS_PIN_SENSED,
    // Converter operating state
    input wire logic STARTUP,
    input wire logic REGULATING,
    input wire logic [1:0] OP_MODE,
    input wire logic LINE_SYNCED,
    input wire logic [psp_pkg::CNT_W-1:0] LINE_PERIOD,
    input wire logic SUPPLY_BELOW_OFF_THRESHOLD,
    // Reactions
    output logic GATE_DRIVE_PIN_ENABLE,
    output logic LOW_POWER_WAIT_STATE,
    output logic FAULT_LATCHED,
    output logic CURRENT_LIMIT_REDUCED,
    output logic IRQ
);

    localparam int CW = psp_pkg::CNT_W;
    localparam int VW = psp_pkg::VAL_W;
    localparam int NF = psp_pkg::NF;
    localparam int NEV = psp_pkg::NEV;
    localparam int RW = psp_pkg::RESTORE_W;
    localparam logic [CW-1:0] HALF_SINE_CNT = HALF_SINE_CYC[CW-1:0];
    localparam logic [CW-1:0] FAST_RESTART_CNT = FAST_RESTART_CYC[CW-1:0];

    // --------------------
    // State
    // --------------------
    logic [31:0] cfg [psp_pkg::CFG_N];
    logic [NEV-1:0] irq_status;
    logic [NEV-1:0] irq_enable;
    psp_pkg::psp_state_e state;
    psp_pkg::psp_state_e next_state;
    logic [CW-1:0] wait_cnt;
    logic [CW-1:0] wait_limit;
    logic [CW-1:0] next_wait_limit;
    logic [CW-1:0] half_sine_cnt;
    logic [RW-1:0] restore_cnt;
    logic [CW-1:0] blank_cnt [NF];
    psp_pkg::psp_sense_s sense;

    assign sense = '{
        cs_mv: CS_MV,
        vout: VOUT_EST,
        iout: IOUT_EST,
        demag_ok: ZERO_CROSS_PIN_SENSED
    };

    // --------------------
    // APB decode
    // --------------------
    wire [5:0] reg_index = PADDR[7:2];
    wire [3:0] cfg_index = PADDR[5:2];
    wire word_aligned = PADDR[1:0] == 2'h0;
    wire hit_cfg = word_aligned && (reg_index < 6'(psp_pkg::CFG_N));
    wire hit_status = PADDR == psp_pkg::ADDR_STATUS;
    wire hit_irq_status = PADDR == psp_pkg::ADDR_IRQ_STATUS;
    wire hit_irq_clear = PADDR == psp_pkg::ADDR_IRQ_CLEAR;
    wire hit_irq_enable = PADDR == psp_pkg::ADDR_IRQ_ENABLE;
    wire addr_ok = hit_cfg | hit_status | hit_irq_status | hit_irq_clear
        | hit_irq_enable;
    wire bus_start = PSEL & PENABLE & ~PREADY;
    wire bus_commit = PSEL & PENABLE & PREADY;
    wire bus_write = bus_commit & PWRITE;

    // --------------------
    // Configuration fields
    // --------------------
    wire [31:0] ctrl = cfg[psp_pkg::CFG_CTRL];
    wire peak_overcurrent_enable = ctrl[psp_pkg::CTRL_PEAK_EN];
    wire adaptive_overvoltage_enable = ctrl[psp_pkg::CTRL_ADAPT_EN];
    wire overvoltage_reaction_select = ctrl[psp_pkg::CTRL_OV_LATCH];
    wire overcurrent_restart_speed = ctrl[psp_pkg::CTRL_FAST];
    wire [6:0] overcurrent_level_one_setting = cfg[psp_pkg::CFG_OCP1][6:0];
    wire [VW-1:0] reduced_overvoltage_level = cfg[psp_pkg::CFG_OV_RED][VW-1:0];
    wire [RW-1:0] restore_periods = cfg[psp_pkg::CFG_RESTORE_N][RW-1:0];
    wire running = state == psp_pkg::ST_RUN;
    wire burst_mode = OP_MODE == psp_pkg::MODE_BURST;

    // Settings below the lowest range fall to the lowest level
    wire [VW-1:0] overcurrent_level_two =
        (overcurrent_level_one_setting >= psp_pkg::OCP1_HIGH_MIN)
            ? psp_pkg::OCP2_HIGH_MV
        : (overcurrent_level_one_setting >= psp_pkg::OCP1_MID_MIN)
            ? psp_pkg::OCP2_MID_MV
            : psp_pkg::OCP2_LOW_MV;
    wire [VW-1:0] output_undervoltage_level =
        cfg[psp_pkg::CFG_DIM_MIN][VW-1:0] >> 1;
    wire [VW-1:0] output_overvoltage_level = CURRENT_LIMIT_REDUCED
        ? reduced_overvoltage_level
        : cfg[psp_pkg::CFG_OV_LVL][VW-1:0];
    wire [CW-1:0] half_sine_period = LINE_SYNCED
        ? LINE_PERIOD : HALF_SINE_CNT;

    // --------------------
    // Fault conditions and blanking limits
    // --------------------
    wire [NF-1:0] cond;
    wire [CW-1:0] limit [NF];
    wire [NF-1:0] trip;

    assign cond[psp_pkg::F_OCP] = sense.cs_mv > overcurrent_level_two;
    assign limit[psp_pkg::F_OCP] = cfg[psp_pkg::CFG_OCP_BLANK][CW-1:0];
    assign cond[psp_pkg::F_UV] = REGULATING
        && (sense.vout < output_undervoltage_level);
    assign limit[psp_pkg::F_UV] = cfg[psp_pkg::CFG_UV_BLANK][CW-1:0];
    assign cond[psp_pkg::F_OV] = sense.vout > output_overvoltage_level;
    assign limit[psp_pkg::F_OV] = burst_mode
        ? cfg[psp_pkg::CFG_BURST_BLANK][CW-1:0]
        : half_sine_period >> 2;
    assign cond[psp_pkg::F_DEMAG] = ~sense.demag_ok;
    assign limit[psp_pkg::F_DEMAG] = half_sine_period >> 1;
    assign cond[psp_pkg::F_IPK] = peak_overcurrent_enable
        && (STARTUP || REGULATING)
        && (sense.iout > cfg[psp_pkg::CFG_IPK_LVL][VW-1:0]);
    assign limit[psp_pkg::F_IPK] = cfg[psp_pkg::CFG_IPK_BLANK][CW-1:0];
    assign cond[psp_pkg::F_START] = STARTUP
        && (sense.vout < cfg[psp_pkg::CFG_START_LVL][VW-1:0]);
    assign limit[psp_pkg::F_START] = cfg[psp_pkg::CFG_START_TMO][CW-1:0];

    // --------------------
    // Blanking counters
    // --------------------
    // Trip only when the condition has lasted longer than the limit
    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++)
        begin : g_blank
            assign trip[gi] = running && cond[gi]
                && (blank_cnt[gi] >= limit[gi]);
            always_ff @(posedge MCLK)
            begin
                if (SYS_RST || !running || !cond[gi])
                    blank_cnt[gi] <= '0;
                else if (!trip[gi])
                    blank_cnt[gi] <= blank_cnt[gi] + 1'b1;
            end
        end
    endgenerate

    // --------------------
    // Reaction selection
    // --------------------
    // Latch outranks auto-restart, which outranks the fast restart
    wire latch_req = trip[psp_pkg::F_OV] & overvoltage_reaction_select;
    wire fast_req = trip[psp_pkg::F_IPK] & overcurrent_restart_speed;
    wire auto_req = trip[psp_pkg::F_OCP]
        | trip[psp_pkg::F_UV]
        | trip[psp_pkg::F_DEMAG]
        | trip[psp_pkg::F_START]
        | (trip[psp_pkg::F_OV] & ~overvoltage_reaction_select)
        | (trip[psp_pkg::F_IPK] & ~overcurrent_restart_speed);

    always_comb
    begin
        next_state = state;
        next_wait_limit = wait_limit;
        case (state)
            psp_pkg::ST_RUN:
            begin
                if (latch_req)
                    next_state = psp_pkg::ST_LATCH;
                else if (auto_req)
                begin
                    next_state = psp_pkg::ST_WAIT;
                    next_wait_limit = cfg[psp_pkg::CFG_RESTART][CW-1:0];
                end
                else if (fast_req)
                begin
                    next_state = psp_pkg::ST_WAIT;
                    next_wait_limit = FAST_RESTART_CNT;
                end
            end
            psp_pkg::ST_WAIT:
            begin
                if (wait_cnt >= wait_limit)
                    next_state = psp_pkg::ST_RUN;
            end
            psp_pkg::ST_LATCH:
            begin
                if (SUPPLY_BELOW_OFF_THRESHOLD)
                    next_state = psp_pkg::ST_RUN;
            end
            default:
                next_state = psp_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            state <= psp_pkg::ST_RUN;
            wait_limit <= '0;
            wait_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            wait_limit <= next_wait_limit;
            wait_cnt <= (state == psp_pkg::ST_WAIT)
                ? wait_cnt + 1'b1 : '0;
        end
    end

    // Gate follows the next state, so it drops one edge after a trip
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            GATE_DRIVE_PIN_ENABLE <= 1'b0;
            LOW_POWER_WAIT_STATE <= 1'b0;
            FAULT_LATCHED <= 1'b0;
        end
        else
        begin
            GATE_DRIVE_PIN_ENABLE <= next_state == psp_pkg::ST_RUN;
            LOW_POWER_WAIT_STATE <= next_state == psp_pkg::ST_WAIT;
            FAULT_LATCHED <= next_state == psp_pkg::ST_LATCH;
        end
    end

    // --------------------
    // Adaptive overvoltage level and restore
    // --------------------
    wire half_sine_tick = half_sine_cnt >= half_sine_period - 1'b1;
    wire restore_watch = CURRENT_LIMIT_REDUCED && running
        && (sense.vout < reduced_overvoltage_level);
    wire restore_done = restore_watch && half_sine_tick
        && (restore_cnt + 1'b1 >= restore_periods);

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            half_sine_cnt <= '0;
        else
            half_sine_cnt <= half_sine_tick ? '0 : half_sine_cnt + 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST || !restore_watch)
            restore_cnt <= '0;
        else if (half_sine_tick)
            restore_cnt <= restore_cnt + 1'b1;
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
            CURRENT_LIMIT_REDUCED <= 1'b0;
        else if (trip[psp_pkg::F_OV] && adaptive_overvoltage_enable)
            CURRENT_LIMIT_REDUCED <= 1'b1;
        else if (restore_done)
            CURRENT_LIMIT_REDUCED <= 1'b0;
    end

    // --------------------
    // Interrupts
    // --------------------
    // New events win over a clear in the same cycle
    wire [NEV-1:0] events = {restore_done, trip};
    wire [NEV-1:0] clear_mask = (bus_write && hit_irq_clear)
        ? PWDATA[NEV-1:0] : '0;
    wire [NEV-1:0] next_irq_status = (irq_status & ~clear_mask) | events;

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            irq_status <= '0;
            IRQ <= 1'b0;
        end
        else
        begin
            irq_status <= next_irq_status;
            IRQ <= |(next_irq_status & irq_enable);
        end
    end

    // --------------------
    // Register file and read path
    // --------------------
    wire [31:0] status_word = {16'h0000, overcurrent_level_two, 1'b0,
        CURRENT_LIMIT_REDUCED, state};
    wire [31:0] read_word =
        hit_cfg ? cfg[cfg_index]
        : hit_status ? status_word
        : hit_irq_status ? 32'(irq_status)
        : hit_irq_enable ? 32'(irq_enable)
        : 32'h0000_0000;

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            for (int i = 0; i < psp_pkg::CFG_N; i++)
                cfg[i] <= psp_pkg::CFG_RST[i];
            irq_enable <= '0;
        end
        else if (bus_write && hit_cfg)
            cfg[cfg_index] <= PWDATA;
        else if (bus_write && hit_irq_enable)
            irq_enable <= PWDATA[NEV-1:0];
    end

    // One wait state: answer in the second access cycle
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST || !bus_start)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= 1'b1;
            PRDATA <= PWRITE ? 32'h0000_0000 : read_word;
            PSLVERR <= ~addr_ok;
        end
    end

endmodule

// ### dv/psp_stage_model.sv
// Behavioural flyback power stage feeding the monitor's sense inputs
module psp_stage_model (
    // Fault scenario from the bench
    input wire logic [2:0] fault_sel,
    // Gate drive from the monitor
    input wire logic gate_on,
    // Sensed and estimated quantities
    output psp_pkg::psp_sense_s sense
);
    timeunit 1ns;
    timeprecision 1ns;

    always_comb
    begin
        sense = '{cs_mv: 12'h200, vout: 12'h400, iout: 12'h400,
            demag_ok: 1'b1};
        case (fault_sel)
            3'h1: sense.cs_mv = 12'h6A4;
            3'h2: sense.vout = 12'h0FF;
            3'h3: sense.vout = 12'hD00;
            3'h4: sense.demag_ok = 1'b0;
            3'h5: sense.iout = 12'h900;
            3'h6: sense.vout = 12'h100;
            3'h7: sense.vout = 12'hB00;
            default: ;
        endcase
        // No switching without gate drive, hence no current at all
        if (gate_on !== 1'b1)
        begin
            sense.cs_mv = 12'h000;
            sense.iout = 12'h000;
        end
    end
endmodule

// ### dv/psp_monitor_checker.sv
// Concurrent checks on the protection monitor's ports
module psp_monitor_checker #(
    parameter int HALF_SINE_CYC = psp_pkg::HALF_SINE_FIXED_CYC
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // Bus answer
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    // Sense and state inputs
    input wire logic [psp_pkg::VAL_W-1:0] CS_MV,
    input wire logic ZERO_CROSS_PIN_SENSED,
    input wire logic LINE_SYNCED,
    input wire logic [psp_pkg::CNT_W-1:0] LINE_PERIOD,
    input wire logic SUPPLY_BELOW_OFF_THRESHOLD,
    // Reactions
    input wire logic GATE_DRIVE_PIN_ENABLE,
    input wire logic LOW_POWER_WAIT_STATE,
    input wire logic FAULT_LATCHED,
    input wire logic CURRENT_LIMIT_REDUCED
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking chk_cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    logic [psp_pkg::CNT_W-1:0] dm_cnt;
    logic [psp_pkg::CNT_W-1:0] dm_lim;
    logic dm_cond;
    assign dm_cond = GATE_DRIVE_PIN_ENABLE && !ZERO_CROSS_PIN_SENSED;
    assign dm_lim = LINE_SYNCED ? (LINE_PERIOD >> 1)
        : (psp_pkg::CNT_W)'(HALF_SINE_CYC / 2);

    // Run length of unsensed output voltage while switching
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST || !dm_cond)
            dm_cnt <= '0;
        else
            dm_cnt <= dm_cnt + 1'b1;
    end

    apb_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("bus answer not after one wait state");
    rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0)
        else $error("read data driven outside answer");
    ocp_trip_a: assert property (
        (GATE_DRIVE_PIN_ENABLE && CS_MV > 12'h640) [*6]
        |=> !GATE_DRIVE_PIN_ENABLE)
        else $error("overcurrent kept gate drive on");
    demag_trip_a: assert property (
        dm_cond && dm_cnt == dm_lim |=> !GATE_DRIVE_PIN_ENABLE)
        else $error("demag shortage kept gate drive on");
    trip_reaction_a: assert property (
        $fell(GATE_DRIVE_PIN_ENABLE) |-> LOW_POWER_WAIT_STATE != FAULT_LATCHED)
        else $error("gate removed without one reaction");
    wait_gate_a: assert property (
        LOW_POWER_WAIT_STATE |-> !GATE_DRIVE_PIN_ENABLE && !FAULT_LATCHED)
        else $error("gate drive during restart wait");
    latch_hold_a: assert property (
        FAULT_LATCHED && !SUPPLY_BELOW_OFF_THRESHOLD |=> FAULT_LATCHED)
        else $error("latch left while supply present");
    latch_release_a: assert property (
        FAULT_LATCHED && SUPPLY_BELOW_OFF_THRESHOLD
        |=> !FAULT_LATCHED && GATE_DRIVE_PIN_ENABLE)
        else $error("latch not released by supply loss");
    reduce_entry_a: assert property (
        $rose(CURRENT_LIMIT_REDUCED) |-> $fell(GATE_DRIVE_PIN_ENABLE))
        else $error("reduced limit without overvoltage trip");
    restore_run_a: assert property (
        $fell(CURRENT_LIMIT_REDUCED)
        |-> GATE_DRIVE_PIN_ENABLE && $past(GATE_DRIVE_PIN_ENABLE))
        else $error("restore outside running state");
endmodule

bind psp_monitor psp_monitor_checker #(.HALF_SINE_CYC(HALF_SINE_CYC)) chk_u (
    .MCLK, .SYS_RST, .PSEL, .PENABLE, .PRDATA, .PREADY, .CS_MV,
    .ZERO_CROSS_PIN_SENSED, .LINE_SYNCED, .LINE_PERIOD,
    .SUPPLY_BELOW_OFF_THRESHOLD, .GATE_DRIVE_PIN_ENABLE,
    .LOW_POWER_WAIT_STATE, .FAULT_LATCHED, .CURRENT_LIMIT_REDUCED);

// ### dv/psp_monitor_tb.sv
// Self-checking bench for the protection monitor
module psp_monitor_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, gate, lpw, latched, reduced, irq, err;
    logic startup = 1'b0;
    logic regulating = 1'b1;
    logic [1:0] op_mode = 2'h0;
    logic line_synced = 1'b0;
    logic [23:0] line_period = 24'h28;
    logic supply_off = 1'b0;
    logic [2:0] fault_sel = 3'h0;
    logic [31:0] irq_en = 32'h0;
    logic [31:0] rd;
    logic [31:0] set_tab [4] = '{32'h36, 32'h37, 32'h48, 32'h49};
    logic [31:0] lvl_tab [4] = '{32'h320, 32'h4B0, 32'h4B0, 32'h640};
    int n;
    int num_errors = 0;
    int samples_checked = 0;
    psp_pkg::psp_sense_s sense;

    always #25 mclk = ~mclk;

    psp_stage_model stage_u (.fault_sel(fault_sel), .gate_on(gate),
        .sense(sense));
    psp_monitor #(.HALF_SINE_CYC(64), .FAST_RESTART_CYC(40)) dut_u (
        .MCLK(mclk), .SYS_RST(sys_rst), .PADDR(paddr), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CS_MV(sense.cs_mv), .VOUT_EST(sense.vout), .IOUT_EST(sense.iout),
        .ZERO_CROSS_PIN_SENSED(sense.demag_ok), .STARTUP(startup),
        .REGULATING(regulating), .OP_MODE(op_mode),
        .LINE_SYNCED(line_synced), .LINE_PERIOD(line_period),
        .SUPPLY_BELOW_OFF_THRESHOLD(supply_off),
        .GATE_DRIVE_PIN_ENABLE(gate), .LOW_POWER_WAIT_STATE(lpw),
        .FAULT_LATCHED(latched), .CURRENT_LIMIT_REDUCED(reduced),
        .IRQ(irq));

    // --------------------
    // Bus and comparison tasks
    // --------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        check(32'(pready), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // Trip delay and wait length both counted in low-phase samples
    task automatic trip(input logic [2:0] code, input int fbit,
        input int tdel, input int wdel);
        int k;
        k = 0;
        @(posedge mclk);
        fault_sel <= code;
        @(negedge mclk);
        while (gate === 1'b1 && k < 400)
        begin
            k++;
            @(negedge mclk);
        end
        check(32'(k), 32'(tdel));
        check(32'(lpw), 32'h1);
        k = 0;
        while (gate === 1'b0 && k < 100)
        begin
            k++;
            @(posedge mclk);
            fault_sel <= 3'h0;
            @(negedge mclk);
        end
        check(32'(k), 32'(wdel));
        rdc(psp_pkg::ADDR_IRQ_STATUS, 32'h1 << fbit);
        check(32'(irq), 32'(irq_en[fbit]));
        wr(psp_pkg::ADDR_IRQ_CLEAR, 32'h1 << fbit);
        rdc(psp_pkg::ADDR_IRQ_STATUS, 32'h0);
        check(32'(irq), 32'h0);
    endtask

    task automatic summarize();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // --------------------
    // Test sequence
    // --------------------
    initial
    begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int i = 0; i < psp_pkg::CFG_N; i++)
            rdc(8'(4 * i), psp_pkg::CFG_RST[i]);
        rdc(psp_pkg::ADDR_IRQ_ENABLE, 32'h0);
        apb(1'b0, 8'h48, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, 8'h06, 32'h5);
        check(32'(err), 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'h04, set_tab[i]);
            apb(1'b0, psp_pkg::ADDR_STATUS, 32'h0);
            check((rd >> 4) & 32'hFFF, lvl_tab[i]);
        end
        wr(8'h04, 32'h32);
        wr(8'h34, 32'h14);
        wr(8'h10, 32'hA);
        wr(8'h2C, 32'hA);
        wr(8'h18, 32'hA);
        wr(8'h24, 32'h8);
        wr(psp_pkg::ADDR_IRQ_ENABLE, 32'h7F);
        irq_en = 32'h7F;
        repeat (2)
        begin
            @(posedge mclk);
            fault_sel <= 3'h1;
            repeat (5) @(posedge mclk);
            fault_sel <= 3'h0;
        end
        @(posedge mclk);
        check(32'(gate), 32'h1);
        trip(3'h1, psp_pkg::F_OCP, 6, 21);
        trip(3'h2, psp_pkg::F_UV, 11, 21);
        fault_sel <= 3'h6;
        repeat (30) @(posedge mclk);
        fault_sel <= 3'h0;
        check(32'(gate), 32'h1);
        trip(3'h3, psp_pkg::F_OV, 17, 21);
        op_mode <= 2'h2;
        trip(3'h3, psp_pkg::F_OV, 9, 21);
        op_mode <= 2'h1;
        wr(psp_pkg::ADDR_IRQ_ENABLE, 32'h77);
        irq_en = 32'h77;
        trip(3'h4, psp_pkg::F_DEMAG, 33, 21);
        line_synced <= 1'b1;
        trip(3'h4, psp_pkg::F_DEMAG, 21, 21);
        line_synced <= 1'b0;
        wr(psp_pkg::ADDR_IRQ_ENABLE, 32'h7F);
        irq_en = 32'h7F;
        wr(8'h00, 32'h9);
        trip(3'h5, psp_pkg::F_IPK, 11, 41);
        wr(8'h00, 32'h1);
        trip(3'h5, psp_pkg::F_IPK, 11, 21);
        wr(8'h00, 32'h0);
        startup <= 1'b1;
        regulating <= 1'b0;
        trip(3'h6, psp_pkg::F_START, 11, 21);
        startup <= 1'b0;
        regulating <= 1'b1;
        wr(8'h00, 32'h4);
        fault_sel <= 3'h3;
        repeat (40) @(posedge mclk);
        fault_sel <= 3'h0;
        repeat (30) @(posedge mclk);
        check(32'({latched, gate, lpw}), 32'h4);
        supply_off <= 1'b1;
        @(posedge mclk);
        supply_off <= 1'b0;
        repeat (2) @(posedge mclk);
        check(32'({latched, gate}), 32'h1);
        rdc(psp_pkg::ADDR_IRQ_STATUS, 32'h4);
        wr(psp_pkg::ADDR_IRQ_CLEAR, 32'h4);
        wr(8'h00, 32'h2);
        trip(3'h3, psp_pkg::F_OV, 17, 21);
        check(32'(reduced), 32'h1);
        trip(3'h7, psp_pkg::F_OV, 17, 21);
        n = 0;
        while (reduced === 1'b1 && n < 400)
        begin
            @(posedge mclk);
            n++;
        end
        check(32'(n >= 170 && n <= 260), 32'h1);
        rdc(psp_pkg::ADDR_IRQ_STATUS, 32'h40);
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        summarize();
    end
endmodule
